/* File: serial_cmd_interp.sv */
// two-wire slave command interpreter for the tag's serial mode
// How it works
// - first written byte picks read, write, control read or control write
// - memory read: code, address high then low, then length
// - read answer is status then data; no data on error or busy
// - memory write: code, address, length, payload; answer is status
// - control read has no parameters; answer is status plus one byte
// - readback bits 6..4 show both masks and the rf stop flag
// - readback bit 3 shows carrier presence
// - readback bits 2..1 are zero, bit 7 is don't care
// - readback bit 0 shows the config check failure
// - control write is code plus one data byte; answer is status
// - bits 6 and 5 mask rf and field interrupts, reset to zero
// - bit 4 halts rf traffic until cleared
// - bit 0 asks for self reset after the status is sent
// - a read without a command returns only the status byte
// - status: result in 3..0, rf irq 5, field irq 4, 7..6 zero
// - result codes: 5 normal, 7 busy, 8 unknown, A range, B read-only
// - direction bit 0 receives a command, 1 transmits the answer
// - irq line low when done, released on read address match
`timescale 1ns/100ps
module serial_cmd_interp
   import tag_serial_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   // two-wire bus pins
   input  wire logic       scl,
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOe,
   // configuration from the system area
   input  wire logic [6:0] slaveAddr,
   input  wire logic [2:0] irqSelect,
   // radio side
   input  wire rf_in_t     rf,
   output ctl_out_t        ctl,
   // interrupt line
   output logic            irqOutN
);
   typedef struct packed {
      logic        sclMeta, sclSync, sclPrev;
      logic        sdaMeta, sdaSync, sdaPrev;
      link_t       link;
      logic [7:0]  shift;
      logic [3:0]  bitCnt;
      logic        isAddr, readDir, sdaDrive;
      phase_t      phase;
      logic [7:0]  cmd;
      logic [15:0] addr;
      logic [7:0]  len;
      logic [8:0]  idx;
      logic [3:0]  result;
      logic        writeOk;
      logic [7:0]  remain;
      ctl_out_t    ctl;
      logic        resetPending;
      logic        serialIrq, rfCmdIrq, fieldIrq, irqOutN;
      logic [7:0]  snapStatus;
   } state_t;

   state_t     st;
   state_t     next_st;
   logic [7:0] mem [MEM_DEPTH];

   logic              sclRise, sclFall, startEv, stopEv;
   logic              rxByte, readMatch, writeMatch, procStart;
   logic              fifoFlush, fifoPop, fifoValid;
   logic              pushValid, pushReady;
   logic [7:0]        pushData, fifoData, txByte, readback, statusByte;
   logic              memWe;
   logic [MEM_AW-1:0] memWAddr;
   logic [16:0]       endAddr;
   logic [8:0]        wrOffset;
   logic              rfCmdSet, fieldSet;

   // -----------------------------------------------------------------
   // pin edges, seen only after the second sync stage
   // -----------------------------------------------------------------
   assign sclRise = st.sclSync && !st.sclPrev;
   assign sclFall = !st.sclSync && st.sclPrev;
   assign startEv = st.sclSync && st.sclPrev && st.sdaPrev && !st.sdaSync;
   assign stopEv  = st.sclSync && st.sclPrev && !st.sdaPrev && st.sdaSync;

   // -----------------------------------------------------------------
   // answer bytes
   // -----------------------------------------------------------------
   // bit 7 is don't care for the host; zero keeps it deterministic
   assign readback = {1'b0, st.ctl.rfCmdMask, st.ctl.fieldMask,
                      st.ctl.rfStop, rf.carrier, 2'b00,
                      rf.bccError};
   assign statusByte = {2'b00, st.rfCmdIrq, st.fieldIrq,
                        st.result};
   // an empty fifo means a bare status query
   assign txByte   = fifoValid ? fifoData : st.snapStatus;
   assign endAddr  = {1'b0, st.addr} + {9'h000, st.len};
   assign wrOffset = st.idx - IDX_DATA;
   assign memWAddr = st.addr[MEM_AW-1:0] + wrOffset[MEM_AW-1:0];
   assign rfCmdSet = rf.rfCmdEvent && irqSelect[SEL_RF_EN]
                     && !st.ctl.rfCmdMask;
   assign fieldSet = rf.fieldEvent && irqSelect[SEL_FIELD_EN]
                     && !st.ctl.fieldMask;

   byte_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_resp_fifo (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .flush    (fifoFlush),
      .inValid  (pushValid),
      .inReady  (pushReady),
      .inData   (pushData),
      .outValid (fifoValid),
      .outReady (fifoPop),
      .outData  (fifoData)
   );

   always_comb begin
      next_st    = st;
      rxByte     = 1'b0;
      readMatch  = 1'b0;
      writeMatch = 1'b0;
      procStart  = 1'b0;
      fifoFlush  = 1'b0;
      fifoPop    = 1'b0;
      pushValid  = 1'b0;
      pushData   = 8'h00;
      memWe      = 1'b0;
      next_st.sclMeta = scl;
      next_st.sclSync = st.sclMeta;
      next_st.sclPrev = st.sclSync;
      next_st.sdaMeta = sdaIn;
      next_st.sdaSync = st.sdaMeta;
      next_st.sdaPrev = st.sdaSync;

      // --------------------------------------------------------------
      // byte engine: shift on rising scl, drive on falling scl
      // --------------------------------------------------------------
      case (st.link)
         L_IDLE: begin
         end
         L_RX: begin
            if (sclRise) begin
               next_st.shift  = {st.shift[6:0], st.sdaSync};
               next_st.bitCnt = st.bitCnt + 1'b1;
            end else if (sclFall && st.bitCnt == BITS_PER_BYTE) begin
               next_st.bitCnt = '0;
               if (st.isAddr && st.shift[7:1] != slaveAddr) begin
                  next_st.link = L_IDLE;
               end else begin
                  next_st.link     = L_RXACK;
                  next_st.sdaDrive = 1'b1;
                  if (st.isAddr) begin
                     next_st.readDir = st.shift[0];
                     readMatch       = st.shift[0];
                     writeMatch      = !st.shift[0];
                  end else begin
                     rxByte = 1'b1;
                  end
               end
            end
         end
         L_RXACK: begin
            if (sclFall) begin
               next_st.isAddr   = 1'b0;
               next_st.sdaDrive = 1'b0;
               next_st.link     = L_RX;
               if (st.readDir) begin
                  fifoPop          = fifoValid;
                  next_st.shift    = txByte;
                  next_st.sdaDrive = !txByte[7];
                  next_st.bitCnt   = 4'h1;
                  next_st.link     = L_TX;
               end
            end
         end
         L_TX: begin
            if (sclFall) begin
               if (st.bitCnt == BITS_PER_BYTE) begin
                  next_st.sdaDrive = 1'b0;
                  next_st.link     = L_TXACK;
               end else begin
                  next_st.sdaDrive = !st.shift[6];
                  next_st.shift    = {st.shift[6:0], 1'b0};
                  next_st.bitCnt   = st.bitCnt + 1'b1;
               end
            end
         end
         L_TXACK: begin
            if (sclRise && st.sdaSync) begin
               next_st.link = L_IDLE;
            end else if (sclFall) begin
               fifoPop          = fifoValid;
               next_st.shift    = txByte;
               next_st.sdaDrive = !txByte[7];
               next_st.bitCnt   = 4'h1;
               next_st.link     = L_TX;
            end
         end
         default: begin
            next_st.link = L_IDLE;
         end
      endcase

      if (startEv) begin
         next_st.link     = L_RX;
         next_st.isAddr   = 1'b1;
         next_st.bitCnt   = '0;
         next_st.sdaDrive = 1'b0;
      end
      if (stopEv) begin
         next_st.link     = L_IDLE;
         next_st.sdaDrive = 1'b0;
      end

      // --------------------------------------------------------------
      // command reception
      // --------------------------------------------------------------
      if (readMatch) begin
         next_st.snapStatus = statusByte;
         if (st.phase != P_IDLE) begin
            next_st.snapStatus[3:0] = RES_BUSY;
         end
         next_st.serialIrq = 1'b0;
         next_st.rfCmdIrq  = 1'b0;
         next_st.fieldIrq  = 1'b0;
      end
      // a new command drops any answer the host never fetched
      if (writeMatch && st.phase == P_IDLE) begin
         fifoFlush     = 1'b1;
         next_st.phase = P_RECV;
         next_st.idx   = IDX_CMD;
      end
      if (rxByte && st.phase == P_RECV) begin
         if (st.idx != IDX_MAX) begin
            next_st.idx = st.idx + 1'b1;
         end
         case (st.idx)
            IDX_CMD:     next_st.cmd = st.shift;
            IDX_ADDR_HI: next_st.addr[15:8] = st.shift;
            IDX_ADDR_LO: next_st.addr[7:0] = st.shift;
            IDX_LEN: begin
               next_st.len     = st.shift;
               // payload is stored only if the whole span is legal
               next_st.writeOk = st.cmd == CMD_MEM_WRITE
                  && st.shift >= LEN_MIN && st.shift <= WRITE_LEN_MAX
                  && ({1'b0, st.addr} + {9'h000, st.shift}) <= MEM_LIMIT
                  && st.addr >= RO_LIMIT && !rf.rfBusy;
            end
            default: begin
               memWe = st.writeOk
                       && wrOffset < {1'b0, st.len};
            end
         endcase
      end

      // --------------------------------------------------------------
      // command execution at the end of the write transfer
      // --------------------------------------------------------------
      if (stopEv && st.phase == P_RECV) begin
         procStart     = st.idx != IDX_CMD;
         next_st.phase = procStart ? P_STATUS : P_IDLE;
         next_st.remain = st.len;
         if (rf.rfBusy) begin
            next_st.result = RES_BUSY;
         end else begin
            case (st.cmd)
               CMD_MEM_READ: begin
                  if (st.idx == IDX_DATA && st.len >= LEN_MIN
                      && st.len <= READ_LEN_MAX
                      && endAddr <= MEM_LIMIT) begin
                     next_st.result = RES_NORMAL;
                  end else begin
                     next_st.result = RES_PARAM;
                  end
               end
               CMD_MEM_WRITE: begin
                  if (st.idx != IDX_DATA + {1'b0, st.len}
                      || st.len < LEN_MIN || st.len > WRITE_LEN_MAX
                      || endAddr > MEM_LIMIT) begin
                     next_st.result = RES_PARAM;
                  end else if (st.addr < RO_LIMIT) begin
                     next_st.result = RES_READONLY;
                  end else begin
                     next_st.result = RES_NORMAL;
                  end
               end
               CMD_REG_READ: begin
                  next_st.remain = 8'h01;
                  next_st.result = (st.idx == IDX_ADDR_HI)
                                   ? RES_NORMAL : RES_PARAM;
               end
               CMD_REG_WRITE: begin
                  if (st.idx == IDX_ADDR_LO) begin
                     next_st.result = RES_NORMAL;
                     next_st.ctl.rfCmdMask =
                        st.addr[8 + CTL_RFCMD_MASK];
                     next_st.ctl.fieldMask =
                        st.addr[8 + CTL_FIELD_MASK];
                     next_st.ctl.rfStop =
                        st.addr[8 + CTL_RF_STOP];
                     next_st.resetPending =
                        st.addr[8 + CTL_RESET];
                  end else begin
                     next_st.result = RES_PARAM;
                  end
               end
               default: next_st.result = RES_UNIMPL;
            endcase
         end
      end

      // --------------------------------------------------------------
      // answer build: status first, then data while the fifo has room
      // --------------------------------------------------------------
      case (st.phase)
         P_STATUS: begin
            pushValid = 1'b1;
            pushData  = statusByte;
            if (pushReady) begin
               // done once the status is queued: a long read would
               // otherwise wait on a host that waits on the irq
               next_st.serialIrq = 1'b1;
               if (st.result == RES_NORMAL && (st.cmd == CMD_MEM_READ
                   || st.cmd == CMD_REG_READ)) begin
                  next_st.phase = P_DATA;
               end else begin
                  next_st.phase = P_IDLE;
               end
            end
         end
         P_DATA: begin
            pushValid = 1'b1;
            pushData  = (st.cmd == CMD_REG_READ)
                        ? readback : mem[st.addr[MEM_AW-1:0]];
            if (pushReady) begin
               next_st.addr   = st.addr + 16'h0001;
               next_st.remain = st.remain - 8'h01;
               if (st.remain == 8'h01) begin
                  next_st.phase = P_IDLE;
               end
            end
         end
         default: begin
         end
      endcase

      // self reset once the host has read the control write answer
      if (stopEv && st.readDir && st.resetPending
          && st.phase == P_IDLE) begin
         next_st.ctl          = '0;
         next_st.resetPending = 1'b0;
         next_st.result       = RES_NONE;
         next_st.serialIrq    = 1'b0;
         next_st.rfCmdIrq     = 1'b0;
         next_st.fieldIrq     = 1'b0;
      end

      // set after clear so a same-cycle event is kept
      if (rfCmdSet) begin
         next_st.rfCmdIrq = 1'b1;
      end
      if (fieldSet) begin
         next_st.fieldIrq = 1'b1;
      end
      next_st.irqOutN = !(next_st.serialIrq || next_st.rfCmdIrq
                          || next_st.fieldIrq);
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st <= '{link: L_IDLE, phase: P_IDLE, irqOutN: 1'b1,
                 sclMeta: 1'b1, sclSync: 1'b1, sclPrev: 1'b1,
                 sdaMeta: 1'b1, sdaSync: 1'b1, sdaPrev: 1'b1,
                 default: '0};
      end else begin
         st <= next_st;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (memWe) begin
         mem[memWAddr] <= st.shift;
      end
   end

   assign sdaOut  = 1'b0;
   assign sdaOe   = st.sdaDrive;
   assign ctl     = st.ctl;
   assign irqOutN = st.irqOutN;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   irq_release_a: assert property (
      readMatch && !rfCmdSet && !fieldSet
      && !(st.phase == P_STATUS && pushReady) |=> irqOutN)
      else $error("irq line not released on read address match");

   irq_on_done_a: assert property (
      st.phase == P_STATUS && pushReady |=> !irqOutN)
      else $error("irq line not asserted when answer is ready");

   status_bits_a: assert property (
      st.phase == P_STATUS |-> pushData[7:6] == 2'b00
      && pushData[5] == st.rfCmdIrq && pushData[3:0] == st.result)
      else $error("status byte layout wrong");

   err_no_data_a: assert property (
      st.phase == P_STATUS && pushReady && st.result != RES_NORMAL
      |=> st.phase == P_IDLE)
      else $error("data pushed after a failing status");

   readback_bits_a: assert property (
      st.phase == P_DATA && st.cmd == CMD_REG_READ
      |-> pushData[2:1] == 2'b00 && pushData[6] == st.ctl.rfCmdMask
      && pushData[0] == rf.bccError)
      else $error("readback byte layout wrong");

   mask_gate_a: assert property (
      st.ctl.rfCmdMask && !st.rfCmdIrq |=> !st.rfCmdIrq)
      else $error("masked rf interrupt was flagged");

   unknown_cmd_a: assert property (
      procStart && !rf.rfBusy && st.cmd != CMD_MEM_READ
      && st.cmd != CMD_MEM_WRITE && st.cmd != CMD_REG_READ
      && st.cmd != CMD_REG_WRITE |=> st.result == RES_UNIMPL)
      else $error("unknown command not reported");

   self_reset_a: assert property (
      stopEv && st.readDir && st.resetPending && st.phase == P_IDLE
      |=> !st.ctl.rfStop && !st.resetPending && st.result == RES_NONE)
      else $error("self reset did not follow the answer");

   read_len_a: assert property (
      procStart && !rf.rfBusy && st.cmd == CMD_MEM_READ
      && st.len == 8'h00 |=> st.result == RES_PARAM)
      else $error("zero read length accepted");
endmodule

/* File: tag_serial_pkg.sv */
// shared constants and types for the serial command interpreter
package tag_serial_pkg;

   // -----------------------------------------------------------------
   // command codes and result codes
   // -----------------------------------------------------------------
   localparam logic [7:0] CMD_MEM_READ  = 8'h08;
   localparam logic [7:0] CMD_MEM_WRITE = 8'h18;
   localparam logic [7:0] CMD_REG_READ  = 8'h68;
   localparam logic [7:0] CMD_REG_WRITE = 8'h78;
   localparam logic [3:0] RES_NONE      = 4'h0;
   localparam logic [3:0] RES_NORMAL    = 4'h5;
   localparam logic [3:0] RES_BUSY      = 4'h7;
   localparam logic [3:0] RES_UNIMPL    = 4'h8;
   localparam logic [3:0] RES_PARAM     = 4'hA;
   localparam logic [3:0] RES_READONLY  = 4'hB;

   // -----------------------------------------------------------------
   // lengths, memory and byte positions
   // -----------------------------------------------------------------
   localparam logic [7:0]  LEN_MIN       = 8'h01;
   localparam logic [7:0]  READ_LEN_MAX  = 8'hFE;
   localparam logic [7:0]  WRITE_LEN_MAX = 8'hFB;
   localparam int          MEM_AW        = 8;
   localparam int          MEM_DEPTH     = 256;
   localparam logic [16:0] MEM_LIMIT     = 17'h00100;
   localparam logic [15:0] RO_LIMIT      = 16'h0010;
   localparam logic [8:0]  IDX_CMD       = 9'h000;
   localparam logic [8:0]  IDX_ADDR_HI   = 9'h001;
   localparam logic [8:0]  IDX_ADDR_LO   = 9'h002;
   localparam logic [8:0]  IDX_LEN       = 9'h003;
   localparam logic [8:0]  IDX_DATA      = 9'h004;
   localparam logic [8:0]  IDX_MAX       = 9'h1FF;
   localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
   localparam int          FIFO_WIDTH    = 8;
   localparam int          FIFO_DEPTH    = 16;

   // -----------------------------------------------------------------
   // bit positions in control and irq select
   // -----------------------------------------------------------------
   localparam int CTL_RFCMD_MASK = 6;
   localparam int CTL_FIELD_MASK = 5;
   localparam int CTL_RF_STOP    = 4;
   localparam int CTL_RESET      = 0;
   localparam int SEL_RF_EN      = 2;
   localparam int SEL_FIELD_EN   = 0;

   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {L_IDLE, L_RX, L_RXACK, L_TX, L_TXACK} link_t;
   typedef enum logic [1:0] {P_IDLE, P_RECV, P_STATUS, P_DATA} phase_t;

   typedef struct packed {
      logic rfBusy;
      logic carrier;
      logic bccError;
      logic rfCmdEvent;
      logic fieldEvent;
   } rf_in_t;

   typedef struct packed {
      logic rfCmdMask;
      logic fieldMask;
      logic rfStop;
   } ctl_out_t;

endpackage

/* File: byte_fifo.sv */
// response byte fifo with valid/ready on both sides and a flush
`timescale 1ns/100ps
module byte_fifo
   import tag_serial_pkg::*;
#(
   parameter int WIDTH = FIFO_WIDTH,
   parameter int DEPTH = FIFO_DEPTH
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             nrst,
   input  wire logic             flush,
   // fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wrPtr;
      logic [AW:0] rdPtr;
   } fifo_state_t;

   fifo_state_t      st;
   fifo_state_t      next_st;
   logic [WIDTH-1:0] store [DEPTH];
   logic             doPush;
   logic             doPop;

   assign inReady  = (st.wrPtr - st.rdPtr) != (AW+1)'(DEPTH);
   assign outValid = st.wrPtr != st.rdPtr;
   assign outData  = store[st.rdPtr[AW-1:0]];
   assign doPush   = inValid && inReady && !flush;
   assign doPop    = outValid && outReady && !flush;

   always_comb begin
      next_st = st;
      if (flush) begin
         next_st.rdPtr = st.wrPtr;
      end else begin
         if (doPush) begin
            next_st.wrPtr = st.wrPtr + 1'b1;
         end
         if (doPop) begin
            next_st.rdPtr = st.rdPtr + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (doPush) begin
         store[st.wrPtr[AW-1:0]] <= inData;
      end
   end
endmodule

/* File: i2c_host_model.sv */
// two-wire bus host model driving clock and data
`timescale 1ns/100ps
module i2c_host_model (
   // clock
   input  wire logic ref_clk,
   // bus pins
   input  wire logic sdaOe,
   output logic      scl,
   output logic      sda
);
   logic hostLow;
   // pull-up: a released line reads high, never the last value
   assign sda = !(hostLow | sdaOe);
   initial begin
      scl = 1'b1;
      hostLow = 1'b0;
   end
   task automatic tick(input logic c, input logic d);
      repeat (5) @(posedge ref_clk);
      scl <= c;
      hostLow <= !d;
   endtask
   // data only moves while scl is low
   task automatic bitx(input logic d, output logic r);
      tick(1'b0, d);
      tick(1'b1, d);
      tick(1'b1, d);
      r = sda;
      tick(1'b0, d);
   endtask
   task automatic byte_x(input logic [7:0] d, input logic ak,
                         output logic [7:0] r, output logic ao);
      for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
      bitx(ak, ao);
   endtask
   task automatic start();
      tick(1'b1, 1'b1);
      tick(1'b1, 1'b0);
      tick(1'b0, 1'b0);
   endtask
   // scl stands high between frames
   task automatic stop();
      tick(1'b0, 1'b0);
      tick(1'b1, 1'b0);
      tick(1'b1, 1'b1);
   endtask
endmodule

/* File: testbench.sv */
// self-checking bench for the serial command interpreter
`timescale 1ns/100ps
module testbench;
   import tag_serial_pkg::*;
   localparam logic [6:0] ADDR = 7'h2A;
   logic       ref_clk = 1'b0;
   logic       nrst = 1'b1;
   logic       scl, sda, sdaOut, sdaOe, irqOutN;
   logic [2:0] irqSelect = 3'h5;
   rf_in_t     rf = '0;
   ctl_out_t   ctl;
   int         mismatches = 0;
   int         tests_run = 0;
   always #4 ref_clk = ~ref_clk;
   i2c_host_model host (.ref_clk(ref_clk), .sdaOe(sdaOe), .scl(scl),
      .sda(sda));
   serial_cmd_interp dut (.ref_clk(ref_clk), .nrst(nrst), .scl(scl),
      .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .slaveAddr(ADDR),
      .irqSelect(irqSelect), .rf(rf), .ctl(ctl), .irqOutN(irqOutN));
   // ---
   // tasks
   // ---
   task automatic chk(input string nm, input logic [7:0] e, g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic send(input logic [7:0] b[$]);
      logic [7:0] r;
      logic       a;
      host.start();
      host.byte_x({ADDR, 1'b0}, 1'b1, r, a);
      chk("ack", 8'h00, {7'h0, a});
      foreach (b[i]) host.byte_x(b[i], 1'b1, r, a);
      host.stop();
   endtask
   // bounded wait on the irq line, then one read transfer
   task automatic fetch(input logic [7:0] e[$], input logic [7:0] m,
                        input logic q);
      logic [7:0] r;
      logic       a;
      int         n;
      n = 0;
      while (irqOutN !== 1'b0 && n < 3000) begin
         @(posedge ref_clk);
         n++;
      end
      chk("irqwait", {7'h0, q}, {7'h0, irqOutN});
      host.start();
      host.byte_x({ADDR, 1'b1}, 1'b1, r, a);
      chk("irq", 8'h01, {7'h0, irqOutN});
      foreach (e[i]) begin
         host.byte_x(8'hFF, i == e.size() - 1, r, a);
         chk("byte", e[i], r & m);
      end
      host.stop();
   endtask
   task automatic pulse();
      @(posedge ref_clk);
      rf.rfCmdEvent <= 1'b1;
      rf.fieldEvent <= 1'b1;
      @(posedge ref_clk);
      rf.rfCmdEvent <= 1'b0;
      rf.fieldEvent <= 1'b0;
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge ref_clk);
      mismatches++;
      conclude();
   end
   initial begin
      logic [7:0] w[$];
      logic [7:0] x[$];
      nrst <= 1'b0;
      repeat (10) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (5) @(posedge ref_clk);
      chk("ctl", 8'h00, {5'h0, ctl});
      chk("sdaout", 8'h00, {7'h0, sdaOut});
      rf <= '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
      send('{CMD_REG_READ});
      fetch('{8'h05, 8'h09}, 8'h7F, 1'b0);
      send('{CMD_REG_WRITE, 8'h70});
      fetch('{8'h05}, 8'hFF, 1'b0);
      chk("ctl", 8'h07, {5'h0, ctl});
      send('{CMD_REG_READ});
      fetch('{8'h05, 8'h79}, 8'h7F, 1'b0);
      pulse();
      fetch('{8'h00}, 8'hF0, 1'b1);
      $display("register test done");
      send('{CMD_REG_WRITE, 8'h00});
      fetch('{8'h05}, 8'hFF, 1'b0);
      pulse();
      fetch('{8'h30}, 8'hF0, 1'b0);
      $display("event test done");
      w = '{CMD_MEM_WRITE, 8'h00, 8'h20, 8'h14};
      x = '{8'h05};
      for (int i = 0; i < 20; i++) begin
         w.push_back(8'h40 + 8'(i));
         x.push_back(8'h40 + 8'(i));
      end
      send(w);
      fetch('{8'h05}, 8'hFF, 1'b0);
      send('{CMD_MEM_READ, 8'h00, 8'h20, 8'h14});
      fetch(x, 8'hFF, 1'b0);
      $display("memory test done");
      send('{CMD_MEM_READ, 8'h00, 8'hFF, 8'h02});
      fetch('{8'h0A, 8'h0A}, 8'hFF, 1'b0);
      send('{CMD_MEM_READ, 8'h00, 8'h20, 8'h00});
      fetch('{8'h0A, 8'h0A}, 8'hFF, 1'b0);
      send('{CMD_REG_READ, 8'h00});
      fetch('{8'h0A, 8'h0A}, 8'hFF, 1'b0);
      send('{CMD_MEM_WRITE, 8'h00, 8'h00, 8'h01, 8'h11});
      fetch('{8'h0B}, 8'hFF, 1'b0);
      send('{8'h33});
      fetch('{8'h08}, 8'hFF, 1'b0);
      rf.rfBusy <= 1'b1;
      send('{CMD_REG_READ});
      fetch('{8'h07, 8'h07}, 8'hFF, 1'b0);
      rf.rfBusy <= 1'b0;
      $display("error test done");
      send('{CMD_REG_WRITE, 8'h71});
      repeat (5) @(posedge ref_clk);
      chk("ctl", 8'h07, {5'h0, ctl});
      fetch('{8'h05}, 8'hFF, 1'b0);
      repeat (5) @(posedge ref_clk);
      chk("ctl", 8'h00, {5'h0, ctl});
      fetch('{8'h00}, 8'hFF, 1'b1);
      $display("self reset test done");
      conclude();
   end
endmodule
